// [pcu_pkg.sv]
// Package for the PCI-side configuration capture and internal bus reset.
// Assumes a single 40 MHz system clock shared by both register ports.
package pcu_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_COMMAND      = 8'h04;
    localparam logic [7:0]  OFS_CTRL_STATUS  = 8'h84;
    localparam logic [7:0]  OFS_PCIX_STATUS  = 8'he4;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          CMD_MEM_EN_BIT   = 1;
    localparam int          CMD_MASTER_BIT   = 2;
    localparam logic [15:0] CMD_RESET        = 16'h0000;
    localparam int          CSR_IB_RESET_BIT = 5;
    localparam int          CSR_IBQ_BUSY_BIT = 14;
    localparam int          CSR_OBQ_BUSY_BIT = 15;
    localparam int          PXS_DEV_LSB      = 3;
    localparam int          PXS_DEV_MSB      = 7;
    localparam int          PXS_BUS_LSB      = 8;
    localparam int          PXS_BUS_MSB      = 15;
    localparam int          CFG_AD_DEV_LSB   = 11;
    localparam int          CFG_AD_DEV_MSB   = 15;
    localparam logic [4:0]  PXS_DEV_RESET    = 5'h1f;
    localparam logic [4:0]  PXS_DEV_PCI      = 5'h00;
    localparam logic [7:0]  PXS_BUS_RESET    = 8'hff;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          RESET_SETTLE_PCI_CLOCKS = 40;
    localparam int          PCI_CLOCKS_PER_CYCLE    = 1;
    localparam int          RESET_HOLD_CYCLES =
        RESET_SETTLE_PCI_CLOCKS * PCI_CLOCKS_PER_CYCLE;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } pcu_req_type;

    typedef struct packed {
        logic        write;
        logic [31:0] ad;
        logic        attr_valid;
        logic [7:0]  attr_bus;
    } pcu_cfg_type;

endpackage : pcu_pkg

// [pcu_regs.sv]
// Configuration capture and internal bus reset register bank.
// Assumes both register ports and the configuration snoop are synchronous
// to sys_clk; read data returns one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - PCI-X capture status has meaning only in PCI-X mode; flagged valid.
// - Device field updates on every config write seen outside internal bus reset; bus field only on PCI-X attribute phases.
// - Config writes capture AD[15:11] as device number in PCI-X mode only.
// - Device number resets to ones; conventional PCI config writes zero it.
// - Bus number loads only from an attribute phase; PCI leaves it.
// - Internal bus reset bit resets bus, registers and config header.
// - Reset bit is readable and writable from both sides.
module pcu_regs #(
    parameter int HOLD_CYCLES = pcu_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // Bus mode and configuration snoop
    input  wire logic               pcix_mode,
    input  wire pcu_pkg::pcu_cfg_type cfg,
    // Internal bus register port
    input  wire pcu_pkg::pcu_req_type ib_req,
    output logic [31:0]             ib_rdata,
    output logic                    ib_rvalid,
    // PCI bus register port
    input  wire pcu_pkg::pcu_req_type pci_req,
    output logic [31:0]             pci_rdata,
    output logic                    pci_rvalid,
    // Read queue occupancy
    input  wire logic               obq_pending,
    input  wire logic               ibq_pending,
    // Status and control outputs
    output logic                    pcix_status_valid,
    output logic                    internal_bus_reset,
    output logic                    bus_master_enable,
    output logic                    memory_enable
);

    // Elaboration check: hold counter is 16 bits wide
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) begin : g_hold_check
        $error("HOLD_CYCLES out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] command_reg;
    logic [4:0]  dev_num_reg;
    logic [7:0]  bus_num_reg;
    logic        ib_reset_reg;
    logic [15:0] hold_cnt_reg;
    logic        obq_busy_reg;
    logic        ibq_busy_reg;
    logic        hold_done;
    logic        ib_reset_wr;
    logic        ib_reset_wval;

    typedef enum logic [0:0] {
        PCU_IDLE_TYPE = 1'b0,
        PCU_HOLD_TYPE = 1'b1
    } pcu_state_type;
    pcu_state_type state_reg;

    function automatic logic is_wr(input pcu_pkg::pcu_req_type r,
                                   input logic [7:0] ofs);
        is_wr = r.wr && (r.addr == ofs);
    endfunction : is_wr

    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input logic [15:0] cmd,
                                              input logic rst_bit,
                                              input logic obq,
                                              input logic ibq,
                                              input logic [4:0] dev,
                                              input logic [7:0] bus);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            pcu_pkg::OFS_COMMAND: begin
                w[15:0] = cmd;
            end
            pcu_pkg::OFS_CTRL_STATUS: begin
                w[pcu_pkg::CSR_IB_RESET_BIT] = rst_bit;
                w[pcu_pkg::CSR_OBQ_BUSY_BIT] = obq;
                w[pcu_pkg::CSR_IBQ_BUSY_BIT] = ibq;
            end
            pcu_pkg::OFS_PCIX_STATUS: begin
                w[pcu_pkg::PXS_DEV_MSB:pcu_pkg::PXS_DEV_LSB] = dev;
                w[pcu_pkg::PXS_BUS_MSB:pcu_pkg::PXS_BUS_LSB] = bus;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        read_word = w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // Reset bit writes from either side; any side may set it
    // ------------------------------------------------------------------
    always_comb begin
        ib_reset_wr   = 1'b0;
        ib_reset_wval = 1'b0;
        if (is_wr(ib_req, pcu_pkg::OFS_CTRL_STATUS)) begin
            ib_reset_wr   = 1'b1;
            ib_reset_wval = ib_req.wdata[pcu_pkg::CSR_IB_RESET_BIT];
        end
        if (is_wr(pci_req, pcu_pkg::OFS_CTRL_STATUS)) begin
            ib_reset_wr   = 1'b1;
            ib_reset_wval = ib_reset_wval |
                            pci_req.wdata[pcu_pkg::CSR_IB_RESET_BIT];
        end
    end

    assign hold_done = (hold_cnt_reg == 16'(HOLD_CYCLES - 1));

    // ------------------------------------------------------------------
    // Internal bus reset sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= PCU_IDLE_TYPE;
            ib_reset_reg <= 1'b0;
            hold_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                PCU_IDLE_TYPE: begin
                    hold_cnt_reg <= 16'h0000;
                    if (ib_reset_wr && ib_reset_wval) begin
                        state_reg    <= PCU_HOLD_TYPE;
                        ib_reset_reg <= 1'b1;
                    end
                end
                PCU_HOLD_TYPE: begin
                    hold_cnt_reg <= hold_cnt_reg + 16'h0001;
                    if (hold_done) begin
                        state_reg    <= PCU_IDLE_TYPE;
                        ib_reset_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg    <= PCU_IDLE_TYPE;
                    ib_reset_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            command_reg <= pcu_pkg::CMD_RESET;
        end else if (ib_reset_reg) begin
            command_reg <= pcu_pkg::CMD_RESET;
        end else if (is_wr(pci_req, pcu_pkg::OFS_COMMAND)) begin
            command_reg <= pci_req.wdata[15:0];
        end else if (is_wr(ib_req, pcu_pkg::OFS_COMMAND)) begin
            command_reg <= ib_req.wdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Configuration write capture
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dev_num_reg <= pcu_pkg::PXS_DEV_RESET;
        end else if (ib_reset_reg) begin
            dev_num_reg <= pcu_pkg::PXS_DEV_RESET;
        end else if (cfg.write) begin
            if (pcix_mode) begin
                dev_num_reg <= cfg.ad[pcu_pkg::CFG_AD_DEV_MSB:
                                      pcu_pkg::CFG_AD_DEV_LSB];
            end else begin
                dev_num_reg <= pcu_pkg::PXS_DEV_PCI;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_num_reg <= pcu_pkg::PXS_BUS_RESET;
        end else if (ib_reset_reg) begin
            bus_num_reg <= pcu_pkg::PXS_BUS_RESET;
        end else if (cfg.write && cfg.attr_valid && pcix_mode) begin
            bus_num_reg <= cfg.attr_bus;
        end
    end

    // ------------------------------------------------------------------
    // Read queue busy tracking
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            obq_busy_reg <= 1'b0;
            ibq_busy_reg <= 1'b0;
        end else begin
            obq_busy_reg <= obq_pending;
            ibq_busy_reg <= ibq_pending;
        end
    end

    // ------------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ib_rdata   <= 32'h0000_0000;
            ib_rvalid  <= 1'b0;
            pci_rdata  <= 32'h0000_0000;
            pci_rvalid <= 1'b0;
        end else begin
            ib_rvalid  <= ib_req.rd;
            pci_rvalid <= pci_req.rd;
            if (ib_req.rd) begin
                ib_rdata <= read_word(ib_req.addr, command_reg,
                                      ib_reset_reg, obq_busy_reg,
                                      ibq_busy_reg, dev_num_reg,
                                      bus_num_reg);
            end
            if (pci_req.rd) begin
                pci_rdata <= read_word(pci_req.addr, command_reg,
                                       ib_reset_reg, obq_busy_reg,
                                       ibq_busy_reg, dev_num_reg,
                                       bus_num_reg);
            end
        end
    end

    assign pcix_status_valid  = pcix_mode;
    assign internal_bus_reset = ib_reset_reg;
    assign bus_master_enable  = command_reg[pcu_pkg::CMD_MASTER_BIT];
    assign memory_enable      = command_reg[pcu_pkg::CMD_MEM_EN_BIT];

endmodule : pcu_regs

`default_nettype wire

// [pcu_regs_end.sv]
// Intentionally no logic; all design lives in pcu_regs.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [pcu_host_model.sv]
// Host model that issues configuration writes to the unit.
// Assumes the bench calls cfg_wr, one cycle at a time.
`timescale 1ns/10ps
`default_nettype none
module pcu_host_model (
    // Clock
    input  wire logic                 sys_clk,
    // Configuration snoop
    output var  pcu_pkg::pcu_cfg_type cfg
);
    initial cfg = '0;
    task automatic cfg_wr(input logic [4:0] dev, input logic [7:0] bn,
                          input logic attr);
        @(posedge sys_clk);
        #2;
        cfg.write      = 1'b1;
        cfg.ad         = {16'h0000, dev, 11'h000};
        cfg.attr_valid = attr;
        cfg.attr_bus   = bn;
        @(posedge sys_clk);
        #2;
        // Released bus shows the inverse of its last value
        cfg.write      = 1'b0;
        cfg.ad         = ~cfg.ad;
        cfg.attr_bus   = ~bn;
    endtask : cfg_wr
endmodule : pcu_host_model
`default_nettype wire

// [pcu_regs_properties.sv]
// Checker for the capture and internal bus reset register bank.
// Assumes it is bound to pcu_regs and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pcu_regs_properties #(
    parameter int HOLD_CYCLES = pcu_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 nrst,
    // Inputs
    input wire logic                 pcix_mode,
    input wire pcu_pkg::pcu_cfg_type cfg,
    input wire pcu_pkg::pcu_req_type ib_req,
    input wire pcu_pkg::pcu_req_type pci_req,
    input wire logic                 obq_pending,
    input wire logic                 ibq_pending,
    // Outputs
    input wire logic [31:0]          ib_rdata,
    input wire logic                 ib_rvalid,
    input wire logic [31:0]          pci_rdata,
    input wire logic                 pci_rvalid,
    input wire logic                 pcix_status_valid,
    input wire logic                 internal_bus_reset,
    input wire logic                 bus_master_enable,
    input wire logic                 memory_enable
);
    localparam int HOLD_LAST = HOLD_CYCLES - 1;
    logic       ib_csr;
    logic       ib_px;
    logic [4:0] cfg_dev;
    assign ib_csr  = ib_req.rd && ib_req.addr == pcu_pkg::OFS_CTRL_STATUS;
    assign ib_px   = ib_req.rd && ib_req.addr == pcu_pkg::OFS_PCIX_STATUS;
    assign cfg_dev = cfg.ad[15:11];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_ib_read_answer: assert property (ib_req.rd |=> ib_rvalid)
        else $error("ib read not answered");
    a_pci_read_answer: assert property (pci_req.rd |=> pci_rvalid)
        else $error("pci read not answered");
    a_mode_flag_eq: assert property (pcix_status_valid == pcix_mode)
        else $error("status valid flag differs from mode");
    a_reset_bit_sets: assert property (
        pci_req.wr && pci_req.addr == pcu_pkg::OFS_CTRL_STATUS
        && pci_req.wdata[5] && !internal_bus_reset |=> internal_bus_reset)
        else $error("reset bit write had no effect");
    a_reset_hold_len: assert property ($rose(internal_bus_reset) |->
        ##HOLD_LAST internal_bus_reset ##1 !internal_bus_reset)
        else $error("internal bus reset length wrong");
    a_enables_forced_off: assert property (
        internal_bus_reset |=> !bus_master_enable && !memory_enable)
        else $error("enables set during internal bus reset");
    a_busy_bits_follow: assert property (
        ib_csr && $stable(obq_pending) && $stable(ibq_pending) |=>
        ib_rdata[15:14] == {$past(obq_pending), $past(ibq_pending)})
        else $error("queue busy bits wrong");
    a_dev_capture: assert property (
        cfg.write && !internal_bus_reset ##1 !cfg.write && !internal_bus_reset
        ##1 ib_px && !cfg.write |=>
        ib_rdata[7:3] == ($past(pcix_mode, 3) ? $past(cfg_dev, 3) : 5'h00))
        else $error("device number capture wrong");
    c_soft_reset: cover property ($rose(internal_bus_reset));
    c_pci_cfg: cover property (cfg.write && !pcix_mode);
    c_pcix_cfg: cover property (cfg.write && pcix_mode && cfg.attr_valid);
endmodule : pcu_regs_properties
bind pcu_regs pcu_regs_properties #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .pcix_mode(pcix_mode), .cfg(cfg),
    .ib_req(ib_req), .pci_req(pci_req), .obq_pending(obq_pending),
    .ibq_pending(ibq_pending), .ib_rdata(ib_rdata), .ib_rvalid(ib_rvalid),
    .pci_rdata(pci_rdata), .pci_rvalid(pci_rvalid),
    .pcix_status_valid(pcix_status_valid),
    .internal_bus_reset(internal_bus_reset),
    .bus_master_enable(bus_master_enable), .memory_enable(memory_enable));
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the register bank with a host model.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int         HOLD = 4;
    localparam logic [7:0] PXS  = pcu_pkg::OFS_PCIX_STATUS;
    localparam logic [7:0] CSR  = pcu_pkg::OFS_CTRL_STATUS;
    localparam logic [7:0] CMD  = pcu_pkg::OFS_COMMAND;
    logic                 sys_clk;
    logic                 nrst;
    logic                 pcix_mode;
    logic                 obq;
    logic                 ibq;
    pcu_pkg::pcu_cfg_type cfg;
    pcu_pkg::pcu_req_type ib_req;
    pcu_pkg::pcu_req_type pci_req;
    logic [31:0]          ib_rdata;
    logic [31:0]          pci_rdata;
    logic                 ib_rvalid;
    logic                 pci_rvalid;
    logic                 pxs_valid;
    logic                 ib_reset;
    logic                 master_en;
    logic                 mem_en;
    int                   fail_count;
    int                   n_checks;
    pcu_host_model host_u (.sys_clk(sys_clk), .cfg(cfg));
    pcu_regs #(.HOLD_CYCLES(HOLD)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .pcix_mode(pcix_mode), .cfg(cfg),
        .ib_req(ib_req), .ib_rdata(ib_rdata), .ib_rvalid(ib_rvalid),
        .pci_req(pci_req), .pci_rdata(pci_rdata), .pci_rvalid(pci_rvalid),
        .obq_pending(obq), .ibq_pending(ibq),
        .pcix_status_valid(pxs_valid), .internal_bus_reset(ib_reset),
        .bus_master_enable(master_en), .memory_enable(mem_en));
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One register access; reads are judged against exp
    task automatic acc(input logic p, input logic w, input logic [7:0] a,
                       input logic [31:0] d, input string what);
        pcu_pkg::pcu_req_type r;
        r = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge sys_clk);
        #2;
        if (p) pci_req = r;
        else ib_req = r;
        @(posedge sys_clk);
        #2;
        ib_req  = '0;
        pci_req = '0;
        if (!w) begin
            chk({what, " valid"}, 32'h1, {31'h0, p ? pci_rvalid : ib_rvalid});
            chk(what, d, p ? pci_rdata : ib_rdata);
        end
    endtask : acc
    task automatic t_reset_values;
        acc(1'b0, 1'b0, PXS, 32'h0000_fff8, "capture reset");
        acc(1'b1, 1'b0, CMD, 32'h0, "command reset");
        acc(1'b0, 1'b0, 8'h10, 32'h0, "unmapped read");
        chk("status valid pci", 32'h0, {31'h0, pxs_valid});
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_capture;
        pcix_mode = 1'b1;
        host_u.cfg_wr(5'h0a, 8'h12, 1'b1);
        acc(1'b1, 1'b0, PXS, 32'h0000_1250, "pcix capture");
        chk("status valid pcix", 32'h1, {31'h0, pxs_valid});
        host_u.cfg_wr(5'h07, 8'h34, 1'b0);
        acc(1'b0, 1'b0, PXS, 32'h0000_1238, "no attribute");
        pcix_mode = 1'b0;
        host_u.cfg_wr(5'h15, 8'h56, 1'b1);
        acc(1'b0, 1'b0, PXS, 32'h0000_1200, "pci capture");
        $display("test capture done");
    endtask : t_capture
    task automatic t_busy;
        obq = 1'b1;
        acc(1'b0, 1'b0, CSR, 32'h0000_8000, "outbound busy");
        obq = 1'b0;
        ibq = 1'b1;
        acc(1'b1, 1'b0, CSR, 32'h0000_4000, "inbound busy");
        ibq = 1'b0;
        $display("test busy done");
    endtask : t_busy
    task automatic t_soft_reset;
        pcix_mode = 1'b1;
        host_u.cfg_wr(5'h03, 8'h44, 1'b1);
        acc(1'b1, 1'b1, CMD, 32'h0000_0006, "");
        chk("enables set", 32'h3, {30'h0, master_en, mem_en});
        acc(1'b0, 1'b1, CMD, 32'h0, "");
        chk("enables clear", 32'h0, {30'h0, master_en, mem_en});
        acc(1'b0, 1'b0, CSR, 32'h0, "queues idle");
        acc(1'b1, 1'b1, CSR, 32'h0000_0020, "");
        chk("reset active", 32'h1, {31'h0, ib_reset});
        acc(1'b0, 1'b0, CSR, 32'h0000_0020, "reset bit read");
        repeat (pcu_pkg::RESET_SETTLE_PCI_CLOCKS) @(posedge sys_clk);
        #2;
        chk("reset over", 32'h0, {31'h0, ib_reset});
        acc(1'b0, 1'b0, PXS, 32'h0000_fff8, "capture cleared");
        acc(1'b1, 1'b0, CSR, 32'h0, "reset bit clear");
        acc(1'b0, 1'b1, CSR, 32'h0000_0020, "");
        chk("ib side reset", 32'h1, {31'h0, ib_reset});
        repeat (pcu_pkg::RESET_SETTLE_PCI_CLOCKS) @(posedge sys_clk);
        #2;
        chk("ib reset over", 32'h0, {31'h0, ib_reset});
        $display("test soft_reset done");
    endtask : t_soft_reset
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial begin
        nrst       = 1'b0;
        pcix_mode  = 1'b0;
        obq        = 1'b0;
        ibq        = 1'b0;
        ib_req     = '0;
        pci_req    = '0;
        fail_count = 0;
        n_checks   = 0;
        repeat (20) @(posedge sys_clk);
        #2;
        nrst = 1'b1;
        t_reset_values();
        t_capture();
        t_busy();
        t_soft_reset();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
